// [common/iabx_pkg.sv]
// Purpose: constants, types and carriers for the increment and bit-branch execution unit
// Assumes: one clock, program and data memories answer one clock after a request
// Notes: one machine cycle is a fixed number of clocks, see MC_CLKS
package iabx_pkg;

  // opcodes handled by this unit
  localparam logic [7:0] OP_INC_DIR = 8'h05;
  localparam logic [6:0] OP_INC_IND_HI = 7'h03; // low bit selects the pointer register
  localparam logic [7:0] OP_INC_DP = 8'ha3;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JBC = 8'h10;

  // instruction lengths in bytes, at program counter width
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;

  // machine cycle timing, in clocks of sys_clk
  localparam int MC_CLKS = 8;
  localparam logic [4:0] LIM_1MC = 5'(MC_CLKS * 1 - 1);
  localparam logic [4:0] LIM_2MC = 5'(MC_CLKS * 2 - 1);
  localparam logic [4:0] CNT_FIRST = 5'h01;
  localparam logic [4:0] CNT_STEP = 5'h01;

  // address layout
  localparam logic [7:0] BIT_RAM_BASE = 8'h20; // bit addresses below 80 live from here
  localparam logic [2:0] BIT_SFR_FILL = 3'h0; // bit-addressable special registers sit on multiples of 8
  localparam logic [2:0] RI_ADDR_TOP = 3'h0; // pointer registers live in the lowest 32 bytes
  localparam logic [1:0] RI_ADDR_MID = 2'h0;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ONES = 8'hff;

  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] DATA_POINTER_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_OP = 3'b000, // request opcode byte
    ST_DEC = 3'b001, // opcode arrives, decode
    ST_B2 = 3'b010, // second byte arrives
    ST_B3 = 3'b011, // third byte arrives
    ST_PTR = 3'b100, // pointer register value arrives
    ST_RMW = 3'b101, // operand arrives, modify
    ST_HOLD = 3'b110 // pad out to the machine cycle count
  } iabx_state_e;

  // program memory request
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } iabx_pm_req_s;

  // data memory request; ind selects indirect space, rmw selects latch read
  typedef struct packed {
    logic rd;
    logic wr;
    logic ind;
    logic rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iabx_dm_req_s;

  // data pointer load from the rest of the core
  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } iabx_dp_wr_s;

endpackage

// [rtl/iabx_exec.sv]
// Purpose: executes direct/indirect byte increment, data pointer increment and the two bit-set jumps
// Assumes: memories on the same clock, read data valid one clock after rd
// Notes: each instruction takes exactly its machine cycles times MC_CLKS clocks
module iabx_exec
  import iabx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  output iabx_pm_req_s pm_req,
  input wire logic [7:0] pm_rdata,
  output iabx_dm_req_s dm_req,
  input wire logic [7:0] dm_rdata,
  input wire logic [1:0] reg_bank,
  input iabx_dp_wr_s dp_wr,
  output logic [15:0] data_pointer,
  output logic [15:0] program_counter,
  output logic instr_done,
  output logic instr_illegal
);

  logic [1:0] rst_sync_ff; // reset release synchroniser
  logic rst_n; // synchronised reset, used everywhere else
  iabx_state_e state_ff; // execution step
  logic [7:0] op_ff; // latched opcode
  logic [7:0] b2_ff; // bit address byte
  logic [7:0] rel_ff; // signed displacement byte
  logic [4:0] cnt_ff; // clocks elapsed in this instruction
  logic [4:0] lim_ff; // last clock index of this instruction
  logic taken_ff; // branch decision
  logic [15:0] pc_ff;
  logic [15:0] data_pointer_ff;
  iabx_pm_req_s pm_req_ff;
  iabx_dm_req_s dm_req_ff;
  logic done_ff;
  logic illegal_ff;
  logic [7:0] bit_mask; // one-hot bit select within the addressed byte
  logic [7:0] bit_byte; // byte that holds the addressed bit
  logic fin; // last clock of the instruction
  logic [15:0] nxt_pc;
  logic [15:0] nxt_data_pointer;
  logic [7:0] inc_byte;
  logic is_inc; // byte increment in progress
  logic dec_dir, dec_ind, dec_dp, dec_jb, dec_jbc; // decode of arriving opcode

  // reset: async assert, release after two clocks
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // opcode decode while the byte is on the bus
  assign dec_dir = (pm_rdata == OP_INC_DIR);
  assign dec_ind = (pm_rdata[7:1] == OP_INC_IND_HI);
  assign dec_dp = (pm_rdata == OP_INC_DP);
  assign dec_jb = (pm_rdata == OP_JB);
  assign dec_jbc = (pm_rdata == OP_JBC);
  assign is_inc = (op_ff == OP_INC_DIR) || (op_ff[7:1] == OP_INC_IND_HI);

  // bit address to byte address: low half in ram, high half in special registers
  assign bit_byte = b2_ff[7] ? {b2_ff[7:3], BIT_SFR_FILL} : BIT_RAM_BASE + {4'h0, b2_ff[6:3]};

  // one-hot mask per bit position
  for (genvar k = 0; k < 8; k++) begin : g_mask
    assign bit_mask[k] = (b2_ff[2:0] == 3'(k));
  end

  // wraps from ff to 00, no flag involved anywhere in this unit
  assign inc_byte = dm_rdata + BYTE_ONE;

  // pointer carry from low into high byte
  assign nxt_data_pointer[7:0] = data_pointer_ff[7:0] + BYTE_ONE;
  assign nxt_data_pointer[15:8] = (data_pointer_ff[7:0] == BYTE_ONES) ? data_pointer_ff[15:8] + BYTE_ONE : data_pointer_ff[15:8];

  assign fin = (state_ff == ST_HOLD) && (cnt_ff == lim_ff);

  // next program counter: step past the instruction, then add the displacement if taken
  always_comb begin
    if (op_ff == OP_JB || op_ff == OP_JBC) begin
      nxt_pc = pc_ff + LEN_3 + (taken_ff ? {{8{rel_ff[7]}}, rel_ff} : 16'h0000);
    end else if (op_ff == OP_INC_DIR) begin
      nxt_pc = pc_ff + LEN_2;
    end else begin
      nxt_pc = pc_ff + LEN_1;
    end
  end

  // step sequencer and byte capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_OP;
      op_ff <= 8'h00;
      b2_ff <= 8'h00;
      rel_ff <= 8'h00;
      lim_ff <= LIM_1MC;
    end else begin
      case (state_ff)
        ST_OP: begin
          state_ff <= ST_DEC;
        end
        ST_DEC: begin
          op_ff <= pm_rdata;
          // machine cycles per opcode; anything else is skipped in one
          lim_ff <= (dec_dp || dec_jb || dec_jbc) ? LIM_2MC : LIM_1MC;
          if (dec_dir || dec_jb || dec_jbc) begin
            state_ff <= ST_B2;
          end else if (dec_ind) begin
            state_ff <= ST_PTR;
          end else begin
            state_ff <= ST_HOLD;
          end
        end
        ST_B2: begin
          b2_ff <= pm_rdata;
          state_ff <= (op_ff == OP_INC_DIR) ? ST_RMW : ST_B3;
        end
        ST_B3: begin
          rel_ff <= pm_rdata; // displacement is the third byte
          state_ff <= ST_RMW;
        end
        ST_PTR: begin
          state_ff <= ST_RMW;
        end
        ST_RMW: begin
          state_ff <= ST_HOLD;
        end
        ST_HOLD: begin
          if (fin) begin
            state_ff <= ST_OP;
          end
        end
        default: begin
          state_ff <= ST_OP;
        end
      endcase
    end
  end

  // clock count within the instruction; ST_OP is clock 0
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 5'h00;
    end else if (state_ff == ST_OP) begin
      cnt_ff <= CNT_FIRST;
    end else begin
      cnt_ff <= cnt_ff + CNT_STEP;
    end
  end

  // program memory fetches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_req_ff <= '0;
    end else begin
      pm_req_ff.rd <= 1'b0;
      if (state_ff == ST_OP) begin
        pm_req_ff <= '{rd: 1'b1, addr: pc_ff};
      end else if (state_ff == ST_DEC && (dec_dir || dec_jb || dec_jbc)) begin
        pm_req_ff <= '{rd: 1'b1, addr: pc_ff + LEN_1};
      end else if (state_ff == ST_B2 && op_ff != OP_INC_DIR) begin
        pm_req_ff <= '{rd: 1'b1, addr: pc_ff + LEN_2};
      end
    end
  end

  // data memory reads and writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dm_req_ff <= '0;
    end else begin
      dm_req_ff.rd <= 1'b0;
      dm_req_ff.wr <= 1'b0;
      case (state_ff)
        ST_DEC: begin
          if (dec_ind) begin
            // fetch the pointer register of the current bank
            dm_req_ff <= '{rd: 1'b1, wr: 1'b0, ind: 1'b0, rmw: 1'b0,
                           addr: {RI_ADDR_TOP, reg_bank, RI_ADDR_MID, pm_rdata[0]}, wdata: 8'h00};
          end
        end
        ST_B2: begin
          if (op_ff == OP_INC_DIR) begin
            dm_req_ff <= '{rd: 1'b1, wr: 1'b0, ind: 1'b0, rmw: 1'b1, addr: pm_rdata, wdata: 8'h00};
          end
        end
        ST_B3: begin
          // of the two jumps only the clearing jump reads the port latch; the plain jump samples pins
          dm_req_ff <= '{rd: 1'b1, wr: 1'b0, ind: 1'b0, rmw: (op_ff == OP_JBC), addr: bit_byte,
                         wdata: 8'h00};
        end
        ST_PTR: begin
          dm_req_ff <= '{rd: 1'b1, wr: 1'b0, ind: 1'b1, rmw: 1'b0, addr: dm_rdata, wdata: 8'h00};
        end
        ST_RMW: begin
          // address and space are kept from the read
          if (is_inc) begin
            dm_req_ff.wr <= 1'b1;
            dm_req_ff.wdata <= inc_byte;
          end else if (op_ff == OP_JBC) begin
            // cleared whether or not the branch is taken
            dm_req_ff.wr <= 1'b1;
            dm_req_ff.wdata <= dm_rdata & ~bit_mask;
          end
          // the plain jump never writes back, so its bit cannot change
        end
        default: begin
        end
      endcase
    end
  end

  // branch decision from the byte read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_ff <= 1'b0;
    end else if (state_ff == ST_DEC) begin
      taken_ff <= 1'b0;
    end else if (state_ff == ST_RMW && (op_ff == OP_JB || op_ff == OP_JBC)) begin
      taken_ff <= |(dm_rdata & bit_mask);
    end
  end

  // program counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= PC_RST;
    end else if (fin) begin
      pc_ff <= nxt_pc;
    end
  end

  // data pointer: the only register pair that increments; instruction wins over a load
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_pointer_ff <= DATA_POINTER_RST;
    end else if (state_ff == ST_DEC && dec_dp) begin
      data_pointer_ff <= nxt_data_pointer;
    end else if (dp_wr.wr) begin
      data_pointer_ff <= dp_wr.data;
    end
  end

  // completion and unknown opcode pulses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      done_ff <= fin;
      illegal_ff <= (state_ff == ST_DEC) && !(dec_dir || dec_ind || dec_dp || dec_jb || dec_jbc);
    end
  end

  assign pm_req = pm_req_ff;
  assign dm_req = dm_req_ff;
  assign data_pointer = data_pointer_ff;
  assign program_counter = pc_ff;
  assign instr_done = done_ff;
  assign instr_illegal = illegal_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  localparam int D1 = 7;  // clocks from ST_OP to last clock, one machine cycle
  localparam int D2 = 15; // same, two machine cycles

  chk_dir_write: assert property (
    state_ff == ST_RMW && op_ff == OP_INC_DIR |=> dm_req.wr && dm_req.wdata == 8'($past(dm_rdata) + 8'h01)
      && dm_req.addr == $past(b2_ff))
    else $error("direct increment write wrong");
  chk_dir_len: assert property (
    fin && op_ff == OP_INC_DIR |-> $past(state_ff, D1) == ST_OP ##1 pc_ff == $past(pc_ff) + 16'h0002)
    else $error("direct increment length or timing wrong");
  chk_ind_ptr: assert property (
    state_ff == ST_PTR |=> dm_req.rd && dm_req.ind && dm_req.addr == $past(dm_rdata))
    else $error("indirect address not taken from pointer register");
  chk_wrap_zero: assert property (
    state_ff == ST_RMW && is_inc && dm_rdata == 8'hff |=> dm_req.wr && dm_req.wdata == 8'h00)
    else $error("increment did not wrap to zero");
  chk_data_pointer_inc: assert property (
    state_ff == ST_DEC && dec_dp |=> data_pointer_ff == 16'($past(data_pointer_ff) + 16'h0001) ##[1:15] fin)
    else $error("data pointer increment wrong");
  chk_data_pointer_carry: assert property (
    state_ff == ST_DEC && dec_dp && data_pointer_ff[7:0] == 8'hff |=> data_pointer_ff[15:8] == 8'($past(data_pointer_ff[15:8]) + 8'h01))
    else $error("low byte carry lost");
  chk_data_pointer_only: assert property (
    !(state_ff == ST_DEC && dec_dp) && !dp_wr.wr |=> $stable(data_pointer_ff))
    else $error("data pointer changed without cause");
  chk_jb_pc: assert property (
    fin && op_ff == OP_JB && !taken_ff |-> $past(state_ff, D2) == ST_OP ##1 pc_ff == $past(pc_ff) + 16'h0003)
    else $error("bit jump fall-through wrong");
  chk_jb_nowrite: assert property (
    op_ff == OP_JB && state_ff == ST_HOLD |-> !dm_req.wr)
    else $error("bit jump wrote the tested bit");
  chk_jbc_clear: assert property (
    state_ff == ST_RMW && op_ff == OP_JBC |=> dm_req.wr && (dm_req.wdata & $past(bit_mask)) == 8'h00)
    else $error("tested bit not cleared");
  chk_jbc_target: assert property (
    fin && op_ff == OP_JBC && taken_ff |=> pc_ff == $past(pc_ff) + 16'h0003 + {{8{$past(rel_ff[7])}}, $past(rel_ff)})
    else $error("branch target wrong");
  chk_jbc_latch: assert property (
    state_ff == ST_B3 |=> dm_req.rd && dm_req.rmw == (op_ff == OP_JBC))
    else $error("latch read select wrong");
  chk_jbc_cycles: assert property (
    fin && op_ff == OP_JBC |-> $past(state_ff, D2) == ST_OP)
    else $error("clearing jump length wrong");

  cov_dir_inc: cover property (fin && op_ff == OP_INC_DIR);
  cov_jbc_taken: cover property (fin && op_ff == OP_JBC && taken_ff);
  cov_jb_fall: cover property (fin && op_ff == OP_JB && !taken_ff);
  cov_data_pointer_carry: cover property (state_ff == ST_DEC && dec_dp && data_pointer_ff[7:0] == 8'hff);

endmodule

// [testbench/iabx_mem_model.sv]
// Purpose: program and data memories facing the execution unit
// Assumes: a read answers while its strobe stands, and the unit samples it at the next edge
// Notes: outside the answer cycle the read buses toggle so a stale byte is never reused
module iabx_mem_model
  import iabx_pkg::*;
#(
  parameter logic [7:0] PORT_ADDR = 8'h90 // one output port with latch and pins
)(
  input wire logic sys_clk,
  input iabx_pm_req_s pm_req,
  output logic [7:0] pm_rdata,
  input iabx_dm_req_s dm_req,
  output logic [7:0] dm_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] prog [0:65535]; // program bytes, loaded by the bench
  logic [7:0] dmem [0:255]; // direct space, port latch included
  logic [7:0] umem [128:255]; // upper ram, indirect space only
  logic [7:0] pins; // level seen on the port pins
  logic upper; // indirect access above 7f
  logic pin_read; // plain read of the port sees the pins, a latch read the latch
  logic [7:0] pm_idle_ff = 8'h5a; // shown while no program read stands
  logic [7:0] dm_idle_ff = 8'ha5; // shown while no data read stands

  assign upper = dm_req.ind && dm_req.addr[7];
  assign pin_read = !dm_req.ind && !dm_req.rmw && (dm_req.addr == PORT_ADDR);

  // idle levels invert every clock so a stale byte is never reused
  always @(posedge sys_clk) begin
    pm_idle_ff <= ~pm_idle_ff;
    dm_idle_ff <= ~dm_idle_ff;
  end

  // reads answer in the strobe's own cycle; the unit takes them at the edge that ends it
  assign pm_rdata = pm_req.rd ? prog[pm_req.addr] : pm_idle_ff;
  assign dm_rdata = !dm_req.rd ? dm_idle_ff : upper ? umem[dm_req.addr] : pin_read ? pins : dmem[dm_req.addr];

  // data write at the edge that ends the strobe cycle
  always @(posedge sys_clk) begin
    if (dm_req.wr && upper) begin
      umem[dm_req.addr] <= dm_req.wdata;
    end else if (dm_req.wr) begin
      dmem[dm_req.addr] <= dm_req.wdata;
    end
  end
endmodule

// [testbench/iabx_exec_test.sv]
// Purpose: self-checking bench for the increment and bit-branch unit
// Assumes: memory model answers in one clock; pc and pointer tracked here
// Notes: instructions are written at the model pc just before they are fetched
module iabx_exec_test
  import iabx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk, rstn;
  iabx_pm_req_s pm_req;
  iabx_dm_req_s dm_req;
  iabx_dp_wr_s dp_wr;
  logic [7:0] pm_rdata, dm_rdata;
  logic [1:0] reg_bank;
  logic [15:0] data_pointer, program_counter;
  logic instr_done, instr_illegal;
  int bad_count, check_count, n, wrs, ill;
  int seed = 32'hdef1a708; // fixed seed
  int dpv [4] = '{32'h12fe, 32'hffff, 32'h00ff, 32'hfffe}; // pointer loads around carries
  logic [15:0] epc, edp; // model pc and pointer
  logic [31:0] r;
  logic [7:0] a, v, p, b, ba, src, rel, op;
  logic bv;

  iabx_exec u_dut (.sys_clk(sys_clk), .rstn(rstn), .pm_req(pm_req), .pm_rdata(pm_rdata),
    .dm_req(dm_req), .dm_rdata(dm_rdata), .reg_bank(reg_bank), .dp_wr(dp_wr),
    .data_pointer(data_pointer), .program_counter(program_counter),
    .instr_done(instr_done), .instr_illegal(instr_illegal));
  iabx_mem_model u_mem (.sys_clk(sys_clk), .pm_req(pm_req), .pm_rdata(pm_rdata),
    .dm_req(dm_req), .dm_rdata(dm_rdata));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // one comparison, counted
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // place one instruction at the model pc, run it, count clocks, writes and illegal pulses
  // a pointer load (ldv >= 0) is sent mid-instruction, never on a pointer increment
  task automatic run(input logic [7:0] b0, b1, b2, input int ldv, input int len, input logic [15:0] npc);
    u_mem.prog[epc] = b0;
    u_mem.prog[epc + 16'h0001] = b1;
    u_mem.prog[epc + 16'h0002] = b2;
    n = 0;
    wrs = 0;
    ill = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
      dp_wr.wr = (ldv >= 0 && n == 4);
      dp_wr.data = 16'(ldv);
      wrs += dm_req.wr;
      ill |= instr_illegal;
    end while (instr_done !== 1'b1 && n < 40);
    check({15'h0000, instr_done}, 16'h0001);
    if (ldv >= 0) edp = 16'(ldv);
    epc = npc;
    check(program_counter, epc);
    check(data_pointer, edp);
    if (len > 0) check(16'(n), 16'(len));
  endtask

  // hang guard, far beyond the roughly 1100 clocks the run needs
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    reg_bank = 2'h0;
    dp_wr = '0;
    epc = PC_RST;
    edp = DATA_POINTER_RST;
    repeat (8) @(posedge sys_clk);
    #1;
    check(program_counter, PC_RST);
    check(data_pointer, DATA_POINTER_RST);
    rstn = 1'b1;
    // an opcode outside the group is skipped as one byte
    run(8'h00, 8'h00, 8'h00, -1, 0, epc + LEN_1);
    check(16'(ill), 16'h0001);
    // direct increment: port latch first, then wraps from ff, then random bytes
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      a = (k == 0) ? 8'h90 : {2'b01, r[5:0]};
      v = (k < 3) ? 8'hff : r[15:8];
      u_mem.dmem[a] = v;
      u_mem.pins = ~v;
      run(OP_INC_DIR, a, 8'h00, (k % 3 == 0) ? int'(r[31:16]) : -1, MC_CLKS, epc + LEN_2);
      check(u_mem.dmem[a], 8'(v + 8'h01));
      check(16'(wrs), 16'h0001);
    end
    // indirect increment through either pointer register of a random bank
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      reg_bank = r[1:0];
      p = r[9:2] | 8'h20; // keep clear of the pointer registers
      v = (k < 2) ? 8'hff : r[23:16];
      u_mem.dmem[{3'h0, r[1:0], 2'h0, r[10]}] = p;
      if (p[7]) u_mem.umem[p] = v;
      else u_mem.dmem[p] = v;
      run({OP_INC_IND_HI, r[10]}, 8'h00, 8'h00, -1, MC_CLKS, epc + LEN_1);
      check(p[7] ? u_mem.umem[p] : u_mem.dmem[p], 8'(v + 8'h01));
    end
    // pointer loads then three increments each, across low and full carries
    foreach (dpv[j]) begin
      run(OP_INC_DIR, 8'h40, 8'h00, dpv[j], MC_CLKS, epc + LEN_2);
      for (int m = 0; m < 3; m++) begin
        edp = edp + 16'h0001;
        run(OP_INC_DP, 8'h00, 8'h00, -1, 2 * MC_CLKS, epc + LEN_1);
        check(16'(wrs), 16'h0000);
      end
    end
    // bit jumps, both opcodes, ram and special bits, port with pins opposite the latch
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      op = r[8] ? OP_JBC : OP_JB;
      b = (k % 4 == 0) ? {5'h12, r[2:0]} : r[7:0];
      ba = b[7] ? {b[7:3], 3'h0} : 8'h20 + {4'h0, b[6:3]};
      v = r[23:16];
      rel = r[31:24];
      u_mem.dmem[ba] = v;
      u_mem.pins = ~v;
      src = (ba == 8'h90 && op == OP_JB) ? ~v : v; // a plain test of the port sees the pins
      bv = src[b[2:0]];
      run(op, b, rel, -1, 2 * MC_CLKS, epc + LEN_3 + (bv ? {{8{rel[7]}}, rel} : 16'h0000));
      check(u_mem.dmem[ba], (op == OP_JBC) ? 8'(v & ~(8'h01 << b[2:0])) : v);
      check(16'(wrs), (op == OP_JBC) ? 16'h0001 : 16'h0000);
    end
    print_verdict();
  end
endmodule
